// [timer_regs.svh]
// Purpose: register offsets, field positions and reset values of the timer
// Assumes: byte addresses on a 32-bit AHB-Lite bus, one word per register
// Notes: definitions only
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH
// ==========================================================
// offsets
`define TMR_CTRL_OFS 8'h00
`define TMR_COUNT_OFS 8'h04
`define TMR_CMPA_OFS 8'h08
`define TMR_CMPP_OFS 8'h0c
// ==========================================================
// control word fields
`define TMR_RUN_BIT 0
`define TMR_CCLR_BIT 2
`define TMR_DPX_BIT 3
`define TMR_POL_BIT 4
`define TMR_OC_BIT 5
`define TMR_FUNC_LSB 6
`define TMR_MODE_LSB 8
// ==========================================================
// reset values and limits
`define TMR_CTRL_RST 10'h000
`define TMR_CMP_RST 10'h000
`define TMR_COUNT_MAX 10'h3ff
`endif

// [timer_pkg.sv]
// Purpose: types shared by the timer files
// Assumes: ten-bit counter
// Notes: offsets live in timer_regs.svh
package timer_pkg;
   typedef enum logic [1:0] {
      MODE_COMPARE = 2'b00,
      MODE_CAPTURE = 2'b01,
      MODE_PWM_PULSE = 2'b10,
      MODE_TIMER = 2'b11
   } op_mode_t;
   typedef enum logic [1:0] {
      FUNC_RISE = 2'b00,
      FUNC_FALL = 2'b01,
      FUNC_BOTH = 2'b10,
      FUNC_PULSE = 2'b11
   } out_func_t;
   typedef struct packed {
      op_mode_t op_mode;
      out_func_t out_func;
      logic output_level_ctrl;
      logic output_invert;
      logic period_duty_swap;
      logic clear_source_select;
   } ctrl_t;
endpackage

// [timer_single_pulse_capture.sv]
// Purpose: single-pulse output and input-capture modes of a 10-bit timer
// Assumes: timer clock is clk_sys_in; pins are asynchronous
// Notes: AHB-Lite slave, zero wait states, always OKAY
// Behaviour
// - mode 10 with function 11 gives one shot pulse on pulse output
// - run-enable rising starts counter and pulse leading edge
// - trigger pin rising edge sets run-enable in single-pulse mode
// - clearing run-enable ends the pulse
// - compare A match clears run-enable, ending the pulse
// - compare A match in single-pulse mode raises interrupt request
// - single-pulse counter zeroes only on run-enable rising
// - compare P, clear source and swap ignored in single-pulse mode
// - mode 01 selects capture of counter by external input
// - capture edge chosen as rising, falling or both by function
// - capture counter starts on run-enable rising
// - selected edge copies counter into compare A, raises interrupt
// - capture counter runs regardless of captures until run-enable falls
// - compare P match zeroes counter and raises interrupt in capture
// - compare P zero lets capture counter reach full count
// - function 11 in capture disables capture, counter still runs
// - capture mode holds pulse output low; output settings ignored
// - counter is ten bits, maximum 3FF
`include "timer_regs.svh"
module timer_single_pulse_capture (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic ext_trigger_pin_in,
   input wire logic capture_input_pin_in,
   output logic pulse_out,
   output logic irq_out
);
   // ==========================================================
   // state
   timer_pkg::ctrl_t ctrl_reg;
   logic counter_run_enable_reg;
   logic run_next;
   logic [9:0] cnt_reg;
   logic [9:0] compare_a_value_reg;
   logic [9:0] compare_p_value_reg;
   logic [2:0] trig_sync_reg;
   logic [2:0] cap_sync_reg;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic sp_mode;
   logic cap_mode;
   logic start;
   logic trig_rise;
   logic cap_hit;
   logic match_a;
   logic match_p;
   logic wr_ctrl;
   logic wr_cmpa;
   logic [31:0] rd_mux;
   // one constant holds the whole control word, run bit included, so both resets agree
   localparam logic [9:0] ctrl_rst_word = `TMR_CTRL_RST;

   // ==========================================================
   // bus slave
   // write data arrives one cycle after the address, so the address is held
   logic addr_ok;
   assign addr_ok = hsel_in & hready_in & htrans_in[1];
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata_out <= 32'h0000_0000;
         hreadyout_out <= 1'b0;
         hresp_out <= 1'b0;
      end else begin
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
         wr_pend_reg <= addr_ok & hwrite_in;
         wr_addr_reg <= haddr_in[7:0];
         if (addr_ok & ~hwrite_in) begin
            hrdata_out <= rd_mux;
         end
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (haddr_in[7:0])
         `TMR_CTRL_OFS: rd_mux = {22'h00_0000, ctrl_reg, 1'b0, counter_run_enable_reg};
         `TMR_COUNT_OFS: rd_mux = {22'h00_0000, cnt_reg};
         `TMR_CMPA_OFS: rd_mux = {22'h00_0000, compare_a_value_reg};
         `TMR_CMPP_OFS: rd_mux = {22'h00_0000, compare_p_value_reg};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   assign wr_ctrl = wr_pend_reg & (wr_addr_reg == `TMR_CTRL_OFS);
   assign wr_cmpa = wr_pend_reg & (wr_addr_reg == `TMR_CMPA_OFS);

   // ==========================================================
   // pin synchronisers; stage 2 against stage 3 gives the edges
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         trig_sync_reg <= 3'h0;
         cap_sync_reg <= 3'h0;
      end else begin
         trig_sync_reg <= {trig_sync_reg[1:0], ext_trigger_pin_in};
         cap_sync_reg <= {cap_sync_reg[1:0], capture_input_pin_in};
      end
   end
   assign trig_rise = trig_sync_reg[1] & ~trig_sync_reg[2];

   // ==========================================================
   // mode decode and comparators
   // pulse mode needs function 11; mode 10 with other codes is pwm, not built here
   assign sp_mode = (ctrl_reg.op_mode == timer_pkg::MODE_PWM_PULSE)
                    & (ctrl_reg.out_func == timer_pkg::FUNC_PULSE);
   assign cap_mode = ctrl_reg.op_mode == timer_pkg::MODE_CAPTURE;
   assign match_a = sp_mode & counter_run_enable_reg & (cnt_reg == compare_a_value_reg);
   // compare P only matters in capture mode; zero means run to full count
   assign match_p = cap_mode & counter_run_enable_reg
                    & (compare_p_value_reg != 10'h000)
                    & (cnt_reg == compare_p_value_reg);

   always_comb begin
      cap_hit = 1'b0;
      if (cap_mode) begin
         unique case (ctrl_reg.out_func)
            timer_pkg::FUNC_RISE: cap_hit = cap_sync_reg[1] & ~cap_sync_reg[2];
            timer_pkg::FUNC_FALL: cap_hit = ~cap_sync_reg[1] & cap_sync_reg[2];
            timer_pkg::FUNC_BOTH: cap_hit = cap_sync_reg[1] ^ cap_sync_reg[2];
            timer_pkg::FUNC_PULSE: cap_hit = 1'b0;
         endcase
      end
   end

   // ==========================================================
   // control and run-enable
   always_comb begin
      run_next = counter_run_enable_reg;
      if (wr_ctrl) begin
         run_next = hwdata_in[`TMR_RUN_BIT];
      end
      if (sp_mode & trig_rise & ~counter_run_enable_reg) begin
         run_next = 1'b1;
      end
      if (match_a) begin
         run_next = 1'b0;
      end
   end
   assign start = run_next & ~counter_run_enable_reg;

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         counter_run_enable_reg <= ctrl_rst_word[`TMR_RUN_BIT];
         ctrl_reg <= timer_pkg::ctrl_t'(ctrl_rst_word[9:2]);
      end else begin
         counter_run_enable_reg <= run_next;
         if (wr_ctrl) begin
            ctrl_reg <= timer_pkg::ctrl_t'(hwdata_in[9:2]);
         end
      end
   end

   // ==========================================================
   // counter
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         cnt_reg <= 10'h000;
      end else if (start) begin
         cnt_reg <= 10'h000;
      end else if (counter_run_enable_reg & ~match_a) begin
         if (match_p) begin
            cnt_reg <= 10'h000;
         end else begin
            cnt_reg <= cnt_reg + 10'h001;
         end
      end
   end

   // ==========================================================
   // compare registers; a capture wins over a software write in the same cycle
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         compare_a_value_reg <= `TMR_CMP_RST;
         compare_p_value_reg <= `TMR_CMP_RST;
      end else begin
         if (cap_hit) begin
            compare_a_value_reg <= cnt_reg;
         end else if (wr_cmpa) begin
            compare_a_value_reg <= hwdata_in[9:0];
         end
         if (wr_pend_reg & (wr_addr_reg == `TMR_CMPP_OFS)) begin
            compare_p_value_reg <= hwdata_in[9:0];
         end
      end
   end

   // ==========================================================
   // outputs
   // level ctrl 1 = active high; invert flips it; forced low when not in pulse mode
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         pulse_out <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         pulse_out <= sp_mode & ((counter_run_enable_reg ~^ ctrl_reg.output_level_ctrl)
                      ^ ctrl_reg.output_invert);
         irq_out <= match_a | cap_hit | match_p;
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   property p_start_zero;
      start |=> (cnt_reg == 10'h000) && counter_run_enable_reg;
   endproperty
   a_start_zero: assert property (p_start_zero) else $error("counter not zeroed on start");

   property p_trig;
      sp_mode && trig_rise && !counter_run_enable_reg |=> counter_run_enable_reg;
   endproperty
   a_trig: assert property (p_trig) else $error("trigger did not start pulse");

   property p_match_a;
      match_a |=> !counter_run_enable_reg && irq_out
         ##1 (pulse_out != $past(pulse_out) || $past(ctrl_reg) != $past(ctrl_reg, 2));
   endproperty
   a_match_a: assert property (p_match_a) else $error("compare A did not end pulse");

   property p_pulse_level;
      sp_mode |=> pulse_out == (($past(counter_run_enable_reg)
         ~^ $past(ctrl_reg.output_level_ctrl)) ^ $past(ctrl_reg.output_invert));
   endproperty
   a_pulse_level: assert property (p_pulse_level) else $error("pulse level wrong");

   property p_sp_count;
      sp_mode && counter_run_enable_reg && !match_a && !start |=> cnt_reg == $past(cnt_reg) + 10'h001;
   endproperty
   a_sp_count: assert property (p_sp_count) else $error("pulse counter not counting");

   property p_capture;
      cap_hit |=> compare_a_value_reg == $past(cnt_reg) && irq_out;
   endproperty
   a_capture: assert property (p_capture) else $error("capture value wrong");

   property p_cap_off;
      cap_mode && ctrl_reg.out_func == timer_pkg::FUNC_PULSE && !wr_cmpa
         |=> $stable(compare_a_value_reg);
   endproperty
   a_cap_off: assert property (p_cap_off) else $error("capture while disabled");

   property p_p_clear;
      match_p && !start |=> cnt_reg == 10'h000 && irq_out;
   endproperty
   a_p_clear: assert property (p_p_clear) else $error("compare P did not clear");

   property p_wrap;
      cap_mode && counter_run_enable_reg && compare_p_value_reg == 10'h000
         && cnt_reg == 10'h3ff && !start |=> cnt_reg == 10'h000;
   endproperty
   a_wrap: assert property (p_wrap) else $error("counter did not wrap at maximum");

   property p_stopped;
      !counter_run_enable_reg && !start |=> $stable(cnt_reg);
   endproperty
   a_stopped: assert property (p_stopped) else $error("counter moved while off");

   property p_cap_no_out;
      cap_mode ##1 cap_mode |-> !pulse_out;
   endproperty
   a_cap_no_out: assert property (p_cap_no_out) else $error("output in capture mode");

   // a trigger edge that arrives with the clearing write wins only while run-enable is already off
   property p_run_clear;
      wr_ctrl && !hwdata_in[`TMR_RUN_BIT] && !(sp_mode && trig_rise && !counter_run_enable_reg)
         |=> !counter_run_enable_reg;
   endproperty
   a_run_clear: assert property (p_run_clear) else $error("run enable not cleared");

   property p_irq_src;
      !match_a && !cap_hit && !match_p |=> !irq_out;
   endproperty
   a_irq_src: assert property (p_irq_src) else $error("interrupt without event");

   property p_cmpa_write;
      wr_cmpa && !cap_hit |=> compare_a_value_reg == $past(hwdata_in[9:0]);
   endproperty
   a_cmpa_write: assert property (p_cmpa_write) else $error("compare A not written");

   c_pulse: cover property (sp_mode && start ##[1:50] match_a);
   c_trig: cover property (sp_mode && trig_rise && !counter_run_enable_reg);
   c_capture: cover property (cap_hit);
   c_p_match: cover property (match_p);
   c_both_edges: cover property (cap_mode && ctrl_reg.out_func == timer_pkg::FUNC_BOTH && cap_hit);
endmodule

// [pin_model.sv]
// Purpose: far-side model of the timer trigger and capture pins
// Assumes: pins sampled by the timer through a three-flop synchroniser
// Notes: callers keep each level for at least two cycles
module pin_model (
   input wire logic clk_sys_in,
   output logic ext_trigger_pin_out,
   output logic capture_input_pin_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      ext_trigger_pin_out = 1'b0;
      capture_input_pin_out = 1'b0;
   end
   // levels change right after an edge so the synchroniser sees a clean step
   task automatic set_trig(input logic v);
      @(posedge clk_sys_in);
      ext_trigger_pin_out <= v;
   endtask
   task automatic set_cap(input logic v);
      @(posedge clk_sys_in);
      capture_input_pin_out <= v;
   endtask
endmodule

// [timer_single_pulse_capture_bench.sv]
// Purpose: self-checking bench for the single-pulse and capture timer
// Assumes: zero-wait AHB-Lite slave, hready looped back from hreadyout
// Notes: expected values come from the control word layout
`include "timer_regs.svh"
module timer_single_pulse_capture_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hready;
   logic hresp, pulse, irq, trig, cap;
   logic [31:0] rd;
   int n_errors = 0;
   int total_checks = 0;
   int irq_cnt = 0;
   int w, base;
   int exp_irq [4] = '{1, 1, 2, 0};
   always #10 clk = ~clk;
   always @(posedge clk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
   pin_model pins (.clk_sys_in(clk), .ext_trigger_pin_out(trig), .capture_input_pin_out(cap));
   timer_single_pulse_capture DUT (.clk_sys_in(clk), .rst_in(rst), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
      .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
      .hresp_out(hresp), .ext_trigger_pin_in(trig), .capture_input_pin_in(cap),
      .pulse_out(pulse), .irq_out(irq));
   // ==========================================================
   // report
   task automatic summarize;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // ==========================================================
   // bus cycles; a stalled slave ends the run instead of hanging it
   task automatic wait_rdy;
      int i;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (hready !== 1'b1 && i < 100);
      if (i >= 100) begin
         n_errors++;
         summarize();
      end
   endtask
   task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
      check({31'h0, hresp}, 32'h0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0);
      check(rd, e);
   endtask
   // width of the next pulse in cycles, bounded both ways
   task automatic pulse_width(output int n);
      int i;
      n = 0;
      for (i = 0; i < 60 && pulse !== 1'b1; i++) @(posedge clk);
      while (pulse === 1'b1 && n < 2000) begin
         @(posedge clk);
         n++;
      end
   endtask
   // ==========================================================
   // sequence
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      wait_rdy();
      rd_chk(`TMR_CTRL_OFS, 32'h0);
      rd_chk(`TMR_COUNT_OFS, 32'h0);
      rd_chk(`TMR_CMPA_OFS, 32'h0);
      rd_chk(`TMR_CMPP_OFS, 32'h0);
      rd_chk(8'h40, 32'h0);
      wr(`TMR_CMPP_OFS, 32'hffff_ffff);
      rd_chk(`TMR_CMPP_OFS, 32'h0000_03ff);
      wr(`TMR_CMPP_OFS, 32'h0000_0003);
      wr(`TMR_CMPA_OFS, 32'h0000_0005);
      // clear source and swap set on purpose; width must still follow compare A
      base = irq_cnt;
      wr(`TMR_CTRL_OFS, 32'h0000_02ed);
      pulse_width(w);
      check(w, 6);
      repeat (3) @(posedge clk);
      check(irq_cnt - base, 1);
      rd_chk(`TMR_CTRL_OFS, 32'h0000_02ec);
      rd_chk(`TMR_COUNT_OFS, 32'h0000_0005);
      base = irq_cnt;
      pins.set_trig(1'b1);
      pulse_width(w);
      check(w, 6);
      check(irq_cnt - base, 1);
      pins.set_trig(1'b0);
      wr(`TMR_CMPA_OFS, 32'h0000_03ff);
      wr(`TMR_CTRL_OFS, 32'h0000_02e1);
      repeat (10) @(posedge clk);
      check(pulse, 1);
      wr(`TMR_CTRL_OFS, 32'h0000_02e0);
      repeat (2) @(posedge clk);
      check(pulse, 0);
      xfer(`TMR_COUNT_OFS, 1'b0, 32'h0);
      rd_chk(`TMR_COUNT_OFS, rd);
      wr(`TMR_CMPP_OFS, 32'h0);
      wr(`TMR_CMPA_OFS, 32'h0);
      // output settings set high; capture mode must keep the pin low
      for (int f = 0; f < 4; f++) begin
         base = irq_cnt;
         wr(`TMR_CTRL_OFS, 32'h0000_0131 | (f << 6));
         pins.set_cap(1'b1);
         repeat (6) @(posedge clk);
         pins.set_cap(1'b0);
         repeat (6) @(posedge clk);
         check(irq_cnt - base, exp_irq[f]);
         check(pulse, 0);
      end
      xfer(`TMR_CMPA_OFS, 1'b0, 32'h0);
      check({31'h0, rd != 0}, 1);
      xfer(`TMR_COUNT_OFS, 1'b0, 32'h0);
      check({31'h0, rd > 20}, 1);
      // stop first: the counter is already past the new compare P and would run to 3FF
      wr(`TMR_CTRL_OFS, 32'h0000_01c0);
      wr(`TMR_CMPP_OFS, 32'h0000_0014);
      base = irq_cnt;
      wr(`TMR_CTRL_OFS, 32'h0000_01c1);
      // period is compare P plus one: clears 21, 42 and 63 cycles after the start
      repeat (66) @(posedge clk);
      check(irq_cnt - base, 3);
      xfer(`TMR_COUNT_OFS, 1'b0, 32'h0);
      check({31'h0, rd <= 20}, 1);
      summarize();
   end
endmodule
